/* File: rtl/comparator_control.sv */
// Overview of operation
// - Result is 1 only when positive input exceeds negative input.
// - Result treated invalid for 2.5 us after the comparator switches on.
// - Hysteresis field offers off plus three levels.
// - Pad output enable drives result onto pin; off by default.
// - Writing 1 to enable bit switches the comparator on.
// - Enabled comparator result is offered to event router automatically.
// - Event output follows result combinationally, unsynchronised.
// - Block has no event inputs.
// - Selected edge of the result sets the comparator flag.
// - Interrupt enable bit gates the comparator interrupt source.
// - Interrupt request asserts when enable and flag are both set.
// - Request holds until software clears the flag or the interrupt enable bit.
// - Idle sleep leaves everything working as in active operation.
// - Standby turns comparator off unless standby run bit set.
// - Standby run updates event, pad and level bit; flag and interrupts only while peripheral clock is requested.
// - Power-down disables comparator and pad regardless of standby bit.
// - Debug halt does not affect the comparator.
// - Low-power setting trades power for longer propagation delay.
// - Edge codes: 0 both, 2 falling, 3 rising, 1 reserved.
// - Writing 1 to the flag clears it; writing 0 does nothing.
// - Status level bit shows result after three-cycle synchroniser.
// - Invert bit inverts the result for every consumer.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module comparator_control
  import comparator_control_pkg::*;
#(
  parameter int startup_count = startup_cycles
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog core
  input wire logic core_result,
  output logic core_enable,
  output logic core_low_power,
  output logic [1:0] hysteresis_select,
  output logic positive_source_select,
  output logic [1:0] negative_source_select,
  // System
  input wire logic [1:0] sleep_state,
  input wire logic peripheral_clock_requested,
  input wire logic debug_halt,
  output logic result_valid,
  output logic pad_out,
  output logic pad_out_enable_n,
  output logic event_out,
  output logic interrupt_request
);
  import comparator_control_pkg::*;

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic [7:0] ctrl;
    logic [7:0] src;
    logic int_enable;
    logic flag;
    logic prev_level;
    logic [15:0] startup;
    logic core_on;
    logic pad_drive;
    logic irq;
    logic [1:0] sleep_q1;
    logic [1:0] sleep_q2;
  } state_t;

  state_t s;
  state_t next_s;
  logic level_sync;
  logic enabled_now;
  logic status_updates;
  logic edge_hit;
  logic [3:0] waddr;
  logic [7:0] wbyte;
  logic do_write;

  // Read data for one register, narrow values in the low byte
  function automatic logic [31:0] read_value(input state_t st, input logic [3:0] a,
                                              input logic lvl);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      first_control_register: v = st.ctrl;
      source_select_register: v = st.src;
      interrupt_control_register: v = {7'h00, st.int_enable};
      status_register: v = {3'h0, lvl, 3'h0, st.flag};
      sleep_state_register: v = {6'h00, st.sleep_q2};
      default: v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction : read_value

  function automatic logic mapped(input logic [3:0] a);
    return (a == first_control_register) || (a == source_select_register) ||
           (a == interrupt_control_register) || (a == status_register) ||
           (a == sleep_state_register);
  endfunction : mapped

  // Synchronised, inverted result; invert reaches status and edge logic
  result_synchroniser #(
    .stages(level_sync_stages)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clock_enable(clock_enable),
    .async_in(core_result ^ s.src[src_invert_bit]),
    .sync_out(level_sync)
  );

  // Combinational next-state logic
  always_comb begin
    next_s = s;
    waddr = s.aw_held ? s.aw_addr : s_axi_awaddr;
    wbyte = s.w_held ? s.w_data : s_axi_wdata[7:0];
    do_write = 1'b0;
    enabled_now = 1'b0;
    status_updates = 1'b0;
    edge_hit = 1'b0;

    // Write address and data may arrive in either order
    if (s.bus == bus_idle) begin
      if (s_axi_awvalid && !s.aw_held) begin
        next_s.aw_held = 1'b1;
        next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_held) begin
        next_s.w_held = 1'b1;
        next_s.w_data = s_axi_wdata[7:0];
        next_s.w_strb0 = s_axi_wstrb[0];
      end
      if ((s.aw_held || s_axi_awvalid) && (s.w_held || s_axi_wvalid)) begin
        do_write = s.w_held ? s.w_strb0 : s_axi_wstrb[0];
        do_write = do_write && mapped(waddr);
        next_s.resp = mapped(waddr) ? bus_okay : bus_slverr;
        next_s.aw_held = 1'b0;
        next_s.w_held = 1'b0;
        next_s.bus = bus_wresp;
      end else if (s_axi_arvalid && !s.aw_held && !s.w_held) begin
        next_s.rdata = read_value(s, s_axi_araddr, level_sync);
        next_s.resp = mapped(s_axi_araddr) ? bus_okay : bus_slverr;
        next_s.bus = bus_rresp;
      end
    end else if (s.bus == bus_wresp && s_axi_bready) begin
      next_s.bus = bus_idle;
    end else if (s.bus == bus_rresp && s_axi_rready) begin
      next_s.bus = bus_idle;
    end

    // Register writes
    if (do_write) begin
      case (waddr)
        first_control_register: next_s.ctrl = wbyte;
        source_select_register: next_s.src = wbyte & 8'h8b;
        interrupt_control_register: next_s.int_enable = wbyte[0];
        default: next_s.ctrl = next_s.ctrl;
      endcase
    end

    // Sleep gating; debug halt deliberately ignored
    next_s.sleep_q1 = sleep_state;
    next_s.sleep_q2 = s.sleep_q1;
    case (s.sleep_q2)
      sleep_standby: enabled_now = s.ctrl[ctrl_enable_bit] && s.ctrl[ctrl_standby_bit];
      sleep_powerdown: enabled_now = 1'b0;
      default: enabled_now = s.ctrl[ctrl_enable_bit];
    endcase
    status_updates = (s.sleep_q2 != sleep_standby) || peripheral_clock_requested;
    next_s.core_on = enabled_now;
    next_s.pad_drive = enabled_now && s.ctrl[ctrl_pad_bit];

    // Start-up window counter after switch-on
    if (!enabled_now) begin
      next_s.startup = 16'(startup_count);
    end else if (s.startup != 16'h0000) begin
      next_s.startup = s.startup - 16'h0001;
    end

    // Edge detection on synchronised level, only when valid and enabled
    if (s.core_on && s.startup == 16'h0000 && status_updates) begin
      case (s.ctrl[ctrl_edge_lsb +: 2])
        any_edge_code: edge_hit = level_sync != s.prev_level;
        falling_edge_code: edge_hit = s.prev_level && !level_sync;
        rising_edge_code: edge_hit = !s.prev_level && level_sync;
        default: edge_hit = 1'b0;
      endcase
    end
    next_s.prev_level = s.core_on ? level_sync : 1'b0;

    // Flag: a new edge wins over a clearing write
    if (edge_hit) begin
      next_s.flag = 1'b1;
    end else if (do_write && waddr == status_register && wbyte[status_flag_bit]) begin
      next_s.flag = 1'b0;
    end
    next_s.irq = next_s.flag && next_s.int_enable;
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{bus: bus_idle, startup: 16'hffff, default: '0};
    end else if (clock_enable) begin
      s <= next_s;
    end
  end

  assign s_axi_awready = (s.bus == bus_idle) && !s.aw_held;
  assign s_axi_wready = (s.bus == bus_idle) && !s.w_held;
  assign s_axi_arready = (s.bus == bus_idle) && !s.aw_held && !s.w_held && !s_axi_awvalid &&
                         !s_axi_wvalid;
  assign s_axi_bvalid = s.bus == bus_wresp;
  assign s_axi_bresp = s.resp;
  assign s_axi_rvalid = s.bus == bus_rresp;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.resp;

  assign core_enable = s.core_on;
  assign core_low_power = s.ctrl[ctrl_lowpower_bit];
  assign hysteresis_select = s.ctrl[ctrl_hys_lsb +: 2];
  assign positive_source_select = s.src[src_pos_bit];
  assign negative_source_select = s.src[src_neg_lsb +: 2];
  assign result_valid = s.core_on && (s.startup == 16'h0000);
  // Unsynchronised on purpose: the event router wants the raw result
  assign event_out = s.core_on && (core_result ^ s.src[src_invert_bit]);
  assign pad_out = s.pad_drive && (core_result ^ s.src[src_invert_bit]);
  assign pad_out_enable_n = !s.pad_drive;
  assign interrupt_request = s.irq;
endmodule : comparator_control
`default_nettype wire

/* File: rtl/comparator_control_pkg.sv */
`default_nettype none
package comparator_control_pkg;
  // Register byte offsets
  localparam logic [3:0] first_control_register = 4'h0;
  localparam logic [3:0] source_select_register = 4'h2;
  localparam logic [3:0] interrupt_control_register = 4'h6;
  localparam logic [3:0] status_register = 4'h7;
  localparam logic [3:0] sleep_state_register = 4'h8;

  // First control register fields
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_hys_lsb = 1;
  localparam int ctrl_edge_lsb = 4;
  localparam int ctrl_pad_bit = 6;
  localparam int ctrl_standby_bit = 7;
  localparam int ctrl_lowpower_bit = 3;

  // Source select register fields
  localparam int src_neg_lsb = 0;
  localparam int src_pos_bit = 3;
  localparam int src_invert_bit = 7;

  // Status fields
  localparam int status_flag_bit = 0;
  localparam int status_level_bit = 4;

  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [1:0] bus_okay = 2'b00;
  localparam logic [1:0] bus_slverr = 2'b10;

  // Interrupt edge codes
  localparam logic [1:0] any_edge_code = 2'h0;
  localparam logic [1:0] falling_edge_code = 2'h2;
  localparam logic [1:0] rising_edge_code = 2'h3;

  // Sleep states
  localparam logic [1:0] sleep_active = 2'h0;
  localparam logic [1:0] sleep_idle = 2'h1;
  localparam logic [1:0] sleep_standby = 2'h2;
  localparam logic [1:0] sleep_powerdown = 2'h3;

  // Start-up timing
  localparam int clock_hz = 25000000;
  localparam real startup_time_us = 2.5;
  localparam int startup_cycles = int'($ceil(startup_time_us * clock_hz / 1.0e6));
  localparam int level_sync_stages = 3;

  typedef enum logic [1:0] {bus_idle, bus_wresp, bus_rresp} bus_state_t;
endpackage : comparator_control_pkg
`default_nettype wire

/* File: rtl/result_synchroniser.sv */
`default_nettype none
// Carries the asynchronous comparator result into the clock domain
module result_synchroniser #(
  parameter int stages = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic async_in,
  output logic sync_out
);
  logic [stages-1:0] chain;

  // Only the last stage is read; earlier stages feed nothing else
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chain <= '0;
    end else if (clock_enable) begin
      chain <= {chain[stages-2:0], async_in};
    end
  end
  assign sync_out = chain[stages-1];
endmodule : result_synchroniser
`default_nettype wire

/* File: tb/comparator_core_model.sv */
`default_nettype none
// Analog core stand-in; an off core toggles its line so no stale level shows
module comparator_core_model (
  input wire logic core_enable,
  input wire logic core_low_power,
  input wire logic [1:0] hysteresis_select,
  input wire logic signed [15:0] pos_mv,
  input wire logic signed [15:0] neg_mv,
  output logic core_result
);
  timeunit 1ns;
  timeprecision 100ps;
  logic signed [15:0] band;
  initial core_result = 1'h0;
  // Polls the inputs; low power answers three times slower
  always begin
    #(core_low_power ? 30 : 10);
    band = hysteresis_select == 2'h0 ? 16'sh0 : hysteresis_select == 2'h1 ? 16'sha :
      hysteresis_select == 2'h2 ? 16'sh19 : 16'sh32;
    if (!core_enable) core_result = !core_result;
    else if (pos_mv - neg_mv > band) core_result = 1'h1;
    else if (pos_mv - neg_mv <= -band) core_result = 1'h0;
  end
endmodule : comparator_core_model
`default_nettype wire

/* File: tb/comparator_control_asserts.sv */
`default_nettype none
module comparator_control_asserts
  import comparator_control_pkg::*;
#(
  parameter int startup_count = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic core_result,
  input wire logic core_enable,
  input wire logic [1:0] sleep_state,
  input wire logic result_valid,
  input wire logic pad_out,
  input wire logic pad_out_enable_n,
  input wire logic event_out,
  input wire logic interrupt_request
);
  logic [7:0] on_count;
  // Enabled cycles, saturating, to bound the start-up mask
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) on_count <= 8'h00;
    else if (!core_enable) on_count <= 8'h00;
    else if (clock_enable && on_count != 8'hff) on_count <= on_count + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Write cycles are excluded since an invert change may mask a result change
  property p_event_tracks;
    core_enable && $stable(core_enable) && $changed(core_result) && !s_axi_bvalid
      && !$past(s_axi_bvalid) |-> $changed(event_out);
  endproperty
  a_event_tracks: assert property (p_event_tracks) else $error("event missed a change");
  property p_pad_idle; pad_out_enable_n |-> !pad_out; endproperty
  a_pad_idle: assert property (p_pad_idle) else $error("pad toggles undriven");
  property p_pad_follows; !pad_out_enable_n && core_enable |-> pad_out == event_out; endproperty
  a_pad_follows: assert property (p_pad_follows) else $error("pad differs from event");
  property p_powerdown; (sleep_state == sleep_powerdown) [*5] |-> !core_enable && pad_out_enable_n;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("core alive in power-down");
  property p_irq_holds;
    interrupt_request && !s_axi_wvalid && !$past(s_axi_wvalid) && !s_axi_awvalid
      && !$past(s_axi_awvalid) |=> interrupt_request;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("request dropped alone");
  property p_valid_early; result_valid |-> core_enable && on_count + 1 >= startup_count; endproperty
  a_valid_early: assert property (p_valid_early) else $error("result valid too soon");
  property p_valid_late; core_enable && on_count >= startup_count + 2 |-> result_valid; endproperty
  a_valid_late: assert property (p_valid_late) else $error("result valid too late");
  property p_quiet_off;
    !core_enable && !$past(core_enable) && !$past(core_enable, 2) |-> !event_out && !pad_out;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("disabled core not quiet");
  property p_one_write; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_one_write: assert property (p_one_write) else $error("response repeated");
  c_irq: cover property ($rose(interrupt_request));
  c_valid: cover property ($rose(result_valid));
  c_pad: cover property (!pad_out_enable_n && pad_out);
endmodule : comparator_control_asserts
bind comparator_control comparator_control_asserts #(.startup_count(startup_count)) checker_i (
  .clock, .rst_n, .clock_enable, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .core_result, .core_enable, .sleep_state, .result_valid, .pad_out, .pad_out_enable_n,
  .event_out, .interrupt_request);
`default_nettype wire

/* File: tb/comparator_control_tb.sv */
`default_nettype none
module comparator_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import comparator_control_pkg::*;
  logic clock = 1'h0, rst_n = 1'h0, clock_enable = 1'h1, s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic peripheral_clock_requested = 1'h0, debug_halt = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'he141;
  logic [1:0] sleep_state = 2'h0, s_axi_bresp, s_axi_rresp, hysteresis_select;
  logic [1:0] negative_source_select;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_result;
  logic core_enable, core_low_power, positive_source_select, result_valid, pad_out;
  logic pad_out_enable_n, event_out, interrupt_request;
  logic signed [15:0] pos_mv = 16'sh0, neg_mv = 16'sh0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int fails = 0, comparisons = 0, cycles = 0;
  comparator_control #(.startup_count(4)) dut (.*);
  comparator_core_model core_i (.*);
  initial forever #20 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // Each channel is released at the edge after its ready was seen high
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ga, gw, gb;
    @(posedge clock);
    bq.push_back((a inside {4'h0, 4'h2, 4'h6, 4'h7}) ? bus_okay : bus_slverr);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    gb = 1'h0;
    while (!gb) begin
      @(negedge clock);
      ga = s_axi_awready;
      gw = s_axi_wready;
      gb = s_axi_bvalid;
      @(posedge clock);
      if (ga) s_axi_awvalid <= 1'h0;
      if (gw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] d);
    logic ga, gr;
    @(posedge clock);
    rq.push_back({((a inside {4'h0, 4'h2, 4'h6, 4'h7, 4'h8}) ? bus_okay : bus_slverr), 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    gr = 1'h0;
    while (!gr) begin
      @(negedge clock);
      ga = s_axi_arready;
      gr = s_axi_rvalid;
      @(posedge clock);
      if (ga) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic vin(input logic signed [15:0] p, input logic signed [15:0] q);
    pos_mv = p;
    neg_mv = q;
    tick(8);
  endtask : vin
  // Answers are settled mid-cycle; oldest note is taken per answer
  always @(negedge clock) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    logic [1:0] codes [3] = '{any_edge_code, falling_edge_code, rising_edge_code};
    tick(6);
    rst_n <= 1'h1;
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h6, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'hc, 8'h00);
    chk("pad_en_n", 1'h1, pad_out_enable_n);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(4'h0, {4'h0, seed[0], i[1:0], 1'h0});
      chk("hys", i[1:0], hysteresis_select);
      chk("low_power", seed[0], core_low_power);
      rd(4'h0, {4'h0, seed[0], i[1:0], 1'h0});
    end
    wr(4'h2, 8'h02);
    chk("neg_sel", 2'h2, negative_source_select);
    wr(4'h6, 8'h01);
    debug_halt <= 1'h1;
    $display("test registers done");
    foreach (codes[k]) begin
      vin(-16'sh5, 16'sh5);
      wr(4'h0, {2'h1, codes[k], 3'h0, 1'h1});
      // Start-up window and synchroniser must pass first, so a short wait covers them
      tick(10);
      wr(4'h7, 8'h01);
      vin(16'sh5, -16'sh5);
      rd(4'h7, {7'h08, codes[k] != falling_edge_code});
      chk("event", 1'h1, event_out);
      chk("pad", 1'h1, pad_out);
      vin(-16'sh5, 16'sh5);
      rd(4'h7, 8'h01);
      chk("irq", 1'h1, interrupt_request);
      wr(4'h7, 8'h00);
      rd(4'h7, 8'h01);
      wr(4'h7, 8'h01);
      tick(2);
      chk("irq", 1'h0, interrupt_request);
    end
    wr(4'h2, 8'h82);
    tick(4);
    chk("event", 1'h1, event_out);
    rd(4'h7, 8'h11);
    $display("test edges done");
    wr(4'h2, 8'h02);
    tick(4);
    wr(4'h7, 8'h01);
    wr(4'h0, 8'hc1);
    sleep_state <= sleep_powerdown;
    tick(8);
    chk("pad_en_n", 1'h1, pad_out_enable_n);
    sleep_state <= sleep_standby;
    vin(16'sh5, -16'sh5);
    chk("event", 1'h1, event_out);
    chk("pad", 1'h1, pad_out);
    vin(-16'sh5, 16'sh5);
    sleep_state <= sleep_active;
    tick(8);
    rd(4'h7, 8'h00);
    wr(4'h0, 8'h41);
    sleep_state <= sleep_standby;
    vin(16'sh5, -16'sh5);
    chk("event", 1'h0, event_out);
    vin(-16'sh5, 16'sh5);
    sleep_state <= sleep_idle;
    tick(10);
    wr(4'h7, 8'h01);
    vin(16'sh5, -16'sh5);
    rd(4'h7, 8'h11);
    wr(4'h6, 8'h00);
    chk("irq", 1'h0, interrupt_request);
    wr(4'h6, 8'h01);
    chk("irq", 1'h1, interrupt_request);
    $display("test sleep done");
    wr(4'h7, 8'h01);
    wr(4'h0, 8'h00);
    tick(10);
    chk("event", 1'h0, event_out);
    chk("irq", 1'h0, interrupt_request);
    $display("test disable done");
    end_of_test();
  end
endmodule : comparator_control_tb
`default_nettype wire
